// [rtl/acb_pkg.sv]
// Package with the register map, field layout, states and timing constants.
package acb_pkg;
  localparam int NCONV = 4;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [3:0][11:0] OFS_SETUP = {12'h0DC, 12'h098, 12'h054, 12'h010};
  localparam int CONV_REQ_LSB = 0;
  localparam int RST_REQ_LSB = 16;
  localparam int MODE_BIT = 27;
  localparam int CNT_LSB = 24;
  localparam logic [31:0] SETUP_RST = 32'h0FFF_FFFF;
  localparam logic [31:0] SETUP_MASK = 32'h0FFF_FFFF;
  localparam int CFG_BITS = 32;
  localparam int CLK_NS = 100;
  localparam int RST_PULSE_NS = 200;
  localparam int CONV_NS = 1000;
  localparam int READ_NS = 1600;
  localparam int SCLK_HALF_NS = 200;
  localparam int RST_CYC_I = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC_I = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC_I = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC_I = SCLK_HALF_NS / CLK_NS;
  localparam logic [7:0] RST_CYC = 8'((RST_CYC_I < 1) ? 1 : RST_CYC_I);
  localparam logic [7:0] CONV_CYC = 8'((CONV_CYC_I < 1) ? 1 : CONV_CYC_I);
  localparam logic [7:0] READ_CYC = 8'((READ_CYC_I < 1) ? 1 : READ_CYC_I);
  localparam logic [7:0] HALF_CYC = 8'((HALF_CYC_I < 1) ? 1 : HALF_CYC_I);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RST = 5'h02,
    ST_CFG = 5'h04,
    ST_SAMP = 5'h08,
    ST_READ = 5'h10
  } acb_state_type;
endpackage

// [rtl/acb_sync3.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module acb_sync3 #(
  parameter int W = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } acb_sync_type;
  acb_sync_type q_ff, nxt_q;
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = din;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.val[i] = q_ff.s3[i];
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign dout = q_ff.val;
endmodule

// [rtl/acb_cfg_shifter.sv]
// Serial transmitter that shifts one setup word out to a converter, MSB first.
`timescale 1ns/1ns
module acb_cfg_shifter #(
  parameter int W = acb_pkg::CFG_BITS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [W-1:0] data,
  output logic sclk,
  output logic sdo,
  output logic csN,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] sh;
    logic [7:0] bitCnt;
    logic [7:0] div;
    logic sclk;
    logic csN;
    logic done;
  } acb_shift_type;
  acb_shift_type q_ff, nxt_q;
  logic tick;
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    tick = (q_ff.div == 8'h01);
    if (q_ff.csN) begin
      if (start) begin
        nxt_q.sh = data;
        nxt_q.bitCnt = 8'(W);
        nxt_q.csN = 1'b0;
        nxt_q.div = acb_pkg::HALF_CYC;
      end
    end else begin
      nxt_q.div = tick ? acb_pkg::HALF_CYC : q_ff.div - 8'h01;
      if (tick) begin
        nxt_q.sclk = ~q_ff.sclk;
        if (q_ff.sclk) begin
          nxt_q.sh = {q_ff.sh[W-2:0], 1'b0};
          nxt_q.bitCnt = q_ff.bitCnt - 8'h01;
          if (q_ff.bitCnt == 8'h01) begin
            nxt_q.csN = 1'b1;
            nxt_q.done = 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '{sh: '0, bitCnt: 8'h00, div: 8'h00, sclk: 1'b0, csN: 1'b1, done: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign sclk = q_ff.sclk;
  assign sdo = q_ff.sh[W-1];
  assign csN = q_ff.csN;
  assign done = q_ff.done;
endmodule

// [rtl/acb_top.sv]
// Converter setup, request and busy tracking with an APB register slave.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module acb_top #(
  parameter int N = acb_pkg::NCONV
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N-1:0] adcBusyPin,
  output logic [N-1:0] convStartPin,
  output logic [N-1:0] resetPin,
  output logic [N-1:0] cfgSclk,
  output logic [N-1:0] cfgSdo,
  output logic [N-1:0] cfgCsN,
  output logic [N-1:0][2:0] chanSel
);
  typedef struct packed {
    logic [N-1:0][31:0] setup;
    acb_pkg::acb_state_type [N-1:0] st;
    logic [N-1:0][7:0] cnt;
    logic [N-1:0][2:0] chan;
    logic [N-1:0] convReq;
    logic [N-1:0] rstReq;
    logic [N-1:0] cfgPend;
    logic [N-1:0] busy;
    logic [N-1:0] convStart;
    logic [N-1:0] rstPin;
    logic [N-1:0] shStart;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acb_top_type;
  acb_top_type q_ff, nxt_q;
  logic [N-1:0] adcBusySync;
  logic [N-1:0] shDone;
  logic [N-1:0][3:0] nAct;
  logic wrDone;
  logic setupPh;

  acb_sync3 #(.W(N)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .din(adcBusyPin),
    .dout(adcBusySync)
  );

  // Active channel count from mode bit and count field.
  for (genvar g = 0; g < N; g++) begin : g_conv
    always_comb begin
      if (q_ff.setup[g][acb_pkg::MODE_BIT]) begin
        nAct[g] = {1'b0, q_ff.setup[g][acb_pkg::CNT_LSB+:3]} + 4'h1;
      end else begin
        nAct[g] = {2'b00, q_ff.setup[g][acb_pkg::CNT_LSB+:2]} + 4'h1;
      end
    end
    acb_cfg_shifter u_shift (
      .core_clk(core_clk),
      .reset(reset),
      .start(q_ff.shStart[g]),
      .data(q_ff.setup[g]),
      .sclk(cfgSclk[g]),
      .sdo(cfgSdo[g]),
      .csN(cfgCsN[g]),
      .done(shDone[g])
    );
  end

  assign wrDone = psel && penable && q_ff.pready && pwrite;
  assign setupPh = psel && !penable;

  always_comb begin
    logic hit;
    logic [31:0] rd;
    hit = 1'b0;
    rd = 32'h0000_0000;
    nxt_q = q_ff;
    nxt_q.pready = 1'b0;
    nxt_q.pslverr = 1'b0;
    nxt_q.shStart = '0;
    nxt_q.convStart = '0;
    // Converter sequencing.
    for (int i = 0; i < N; i++) begin
      case (q_ff.st[i])
        acb_pkg::ST_IDLE: begin
          if (q_ff.rstReq[i]) begin
            nxt_q.st[i] = acb_pkg::ST_RST;
            nxt_q.rstPin[i] = 1'b1;
            nxt_q.cnt[i] = acb_pkg::RST_CYC - 8'h01;
          end else if (q_ff.cfgPend[i]) begin
            nxt_q.st[i] = acb_pkg::ST_CFG;
            nxt_q.shStart[i] = 1'b1;
            nxt_q.cfgPend[i] = 1'b0;
          end else if (q_ff.convReq[i]) begin
            nxt_q.st[i] = acb_pkg::ST_SAMP;
            nxt_q.convReq[i] = 1'b0;
            nxt_q.chan[i] = 3'h0;
            nxt_q.convStart[i] = 1'b1;
            nxt_q.cnt[i] = acb_pkg::CONV_CYC - 8'h01;
          end
        end
        acb_pkg::ST_RST: begin
          if (q_ff.cnt[i] == 8'h00) begin
            nxt_q.rstPin[i] = 1'b0;
            nxt_q.rstReq[i] = 1'b0;
            nxt_q.st[i] = acb_pkg::ST_CFG;
            nxt_q.shStart[i] = 1'b1;
            nxt_q.cfgPend[i] = 1'b0;
          end else begin
            nxt_q.cnt[i] = q_ff.cnt[i] - 8'h01;
          end
        end
        acb_pkg::ST_CFG: begin
          if (shDone[i]) begin
            nxt_q.st[i] = acb_pkg::ST_IDLE;
          end
        end
        acb_pkg::ST_SAMP: begin
          if (q_ff.cnt[i] != 8'h00) begin
            nxt_q.cnt[i] = q_ff.cnt[i] - 8'h01;
          end else if (!adcBusySync[i]) begin
            nxt_q.st[i] = acb_pkg::ST_READ;
            nxt_q.cnt[i] = acb_pkg::READ_CYC - 8'h01;
          end
        end
        acb_pkg::ST_READ: begin
          if (q_ff.cnt[i] != 8'h00) begin
            nxt_q.cnt[i] = q_ff.cnt[i] - 8'h01;
          end else if ({1'b0, q_ff.chan[i]} == nAct[i] - 4'h1) begin
            nxt_q.st[i] = acb_pkg::ST_IDLE;
          end else begin
            nxt_q.chan[i] = q_ff.chan[i] + 3'h1;
            nxt_q.st[i] = acb_pkg::ST_SAMP;
            nxt_q.convStart[i] = 1'b1;
            nxt_q.cnt[i] = acb_pkg::CONV_CYC - 8'h01;
          end
        end
        default: begin
          nxt_q.st[i] = acb_pkg::ST_IDLE;
        end
      endcase
    end
    // Read decode and setup-phase answer.
    if (paddr == acb_pkg::OFS_CTRL) begin
      hit = 1'b1;
      rd[acb_pkg::CONV_REQ_LSB+:N] = q_ff.convReq;
      rd[acb_pkg::RST_REQ_LSB+:N] = q_ff.rstReq;
    end
    if (paddr == acb_pkg::OFS_STAT) begin
      hit = 1'b1;
      rd[N-1:0] = q_ff.busy;
    end
    for (int i = 0; i < N; i++) begin
      if (paddr == acb_pkg::OFS_SETUP[i]) begin
        hit = 1'b1;
        rd = q_ff.setup[i];
      end
    end
    if (setupPh) begin
      nxt_q.pready = 1'b1;
      nxt_q.pslverr = !hit;
      nxt_q.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    // Writes come last so a request set wins over a clear.
    if (wrDone) begin
      if (paddr == acb_pkg::OFS_CTRL) begin
        nxt_q.convReq = nxt_q.convReq | pwdata[acb_pkg::CONV_REQ_LSB+:N];
        nxt_q.rstReq = nxt_q.rstReq | pwdata[acb_pkg::RST_REQ_LSB+:N];
      end
      for (int i = 0; i < N; i++) begin
        if (paddr == acb_pkg::OFS_SETUP[i]) begin
          nxt_q.setup[i] = pwdata & acb_pkg::SETUP_MASK;
          nxt_q.cfgPend[i] = 1'b1;
        end
      end
    end
    for (int i = 0; i < N; i++) begin
      nxt_q.busy[i] = (nxt_q.st[i] != acb_pkg::ST_IDLE) || nxt_q.cfgPend[i]
        || nxt_q.rstReq[i] || nxt_q.convReq[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < N; i++) begin
        q_ff.setup[i] <= acb_pkg::SETUP_RST;
        q_ff.st[i] <= acb_pkg::ST_IDLE;
      end
      q_ff.cnt <= '0;
      q_ff.chan <= '0;
      q_ff.convReq <= '0;
      q_ff.rstReq <= '0;
      q_ff.cfgPend <= '0;
      q_ff.busy <= '0;
      q_ff.convStart <= '0;
      q_ff.rstPin <= '0;
      q_ff.shStart <= '0;
      q_ff.prdata <= 32'h0000_0000;
      q_ff.pready <= 1'b0;
      q_ff.pslverr <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata = q_ff.prdata;
  assign pready = q_ff.pready;
  assign pslverr = q_ff.pslverr;
  assign convStartPin = q_ff.convStart;
  assign resetPin = q_ff.rstPin;
  assign chanSel = q_ff.chan;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_stat_read;
    setupPh && !pwrite && paddr == acb_pkg::OFS_STAT |=> prdata == {28'h000_0000, $past(q_ff.busy[3:0])};
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read mismatch");

  property p_busy_samp;
    q_ff.st[0] == acb_pkg::ST_SAMP || q_ff.st[0] == acb_pkg::ST_READ |-> q_ff.busy[0];
  endproperty
  a_busy_samp: assert property (p_busy_samp) else $error("not busy while sampling");

  property p_busy_cfg;
    q_ff.st[1] == acb_pkg::ST_RST || q_ff.st[1] == acb_pkg::ST_CFG |-> q_ff.busy[1];
  endproperty
  a_busy_cfg: assert property (p_busy_cfg) else $error("not busy in reset or setup");

  property p_setup_wr;
    wrDone && paddr == acb_pkg::OFS_SETUP[1] |=> q_ff.setup[1] == ($past(pwdata) & acb_pkg::SETUP_MASK);
  endproperty
  a_setup_wr: assert property (p_setup_wr) else $error("setup write lost");

  property p_setup_pend;
    wrDone && paddr == acb_pkg::OFS_SETUP[2] |=> q_ff.cfgPend[2] && q_ff.busy[2];
  endproperty
  a_setup_pend: assert property (p_setup_pend) else $error("setup write not queued");

  property p_busy_hold;
    q_ff.st[0] == acb_pkg::ST_CFG && !shDone[0] |=> q_ff.busy[0] && q_ff.st[0] == acb_pkg::ST_CFG;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before send end");

  property p_post_rst;
    q_ff.st[2] == acb_pkg::ST_RST && q_ff.cnt[2] == 8'h00 |=> q_ff.st[2] == acb_pkg::ST_CFG
      && q_ff.shStart[2] && !q_ff.rstReq[2] && !resetPin[2];
  endproperty
  a_post_rst: assert property (p_post_rst) else $error("no auto setup after reset");

  property p_rst_pulse;
    q_ff.st[2] == acb_pkg::ST_IDLE && q_ff.rstReq[2] |=> resetPin[2] [*2];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

  property p_df_count;
    !q_ff.setup[0][acb_pkg::MODE_BIT] |-> nAct[0] == {2'b00, q_ff.setup[0][25:24]} + 4'h1 && nAct[0] <= 4'h4;
  endproperty
  a_df_count: assert property (p_df_count) else $error("differential count wrong");

  property p_se_count;
    q_ff.setup[0][acb_pkg::MODE_BIT] |-> nAct[0] == {1'b0, q_ff.setup[0][26:24]} + 4'h1;
  endproperty
  a_se_count: assert property (p_se_count) else $error("single-ended count wrong");

  property p_chan_range;
    q_ff.st[0] == acb_pkg::ST_SAMP |-> {1'b0, q_ff.chan[0]} < nAct[0];
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel beyond count");

  property p_chan_start;
    q_ff.st[0] == acb_pkg::ST_IDLE ##1 q_ff.st[0] == acb_pkg::ST_SAMP |-> q_ff.chan[0] == 3'h0;
  endproperty
  a_chan_start: assert property (p_chan_start) else $error("scan not from channel 0");

  property p_chan_step;
    q_ff.st[0] == acb_pkg::ST_READ ##1 q_ff.st[0] == acb_pkg::ST_SAMP |-> q_ff.chan[0] == $past(q_ff.chan[0]) + 3'h1;
  endproperty
  a_chan_step: assert property (p_chan_step) else $error("channel order broken");

  property p_pend_wait;
    q_ff.cfgPend[0] && q_ff.st[0] == acb_pkg::ST_READ && q_ff.cnt[0] != 8'h00 |=> q_ff.st[0] != acb_pkg::ST_CFG;
  endproperty
  a_pend_wait: assert property (p_pend_wait) else $error("setup sent during readout");

  c_setup_send: cover property (q_ff.st[0] == acb_pkg::ST_CFG ##1 q_ff.st[0] == acb_pkg::ST_IDLE);
  c_full_scan: cover property (q_ff.st[0] == acb_pkg::ST_READ && q_ff.chan[0] == 3'h7);
  c_reset_seq: cover property (q_ff.st[2] == acb_pkg::ST_RST ##1 q_ff.st[2] == acb_pkg::ST_CFG);
  c_unmapped: cover property (pready && pslverr);
endmodule

// [dv/acb_adc_model.sv]
// Behavioural model of the four converters behind the setup, reset and conversion pins.
`timescale 1ns/1ns
module acb_adc_model #(
  parameter int N = 4
) (
  input wire logic core_clk,
  input wire logic [N-1:0] convStartPin,
  input wire logic [N-1:0] resetPin,
  input wire logic [N-1:0] cfgSclk,
  input wire logic [N-1:0] cfgSdo,
  input wire logic [N-1:0] cfgCsN,
  input wire logic [7:0] busyLen,
  output logic [N-1:0] adcBusyPin,
  output logic [N-1:0][31:0] cfgWord,
  output logic [N-1:0][7:0] frameCnt,
  output logic [N-1:0][7:0] rstCnt
);
  logic [N-1:0] sclkOld = '0;
  logic [N-1:0] csOld = '1;
  logic [N-1:0][31:0] shiftReg = '0;
  logic [N-1:0][7:0] bitCnt = '0;
  logic [N-1:0][7:0] busyLeft = '0;
  initial begin
    adcBusyPin = '0;
    cfgWord = '0;
    frameCnt = '0;
    rstCnt = '0;
  end
  always @(posedge core_clk) begin
    for (int i = 0; i < N; i++) begin
      sclkOld[i] <= cfgSclk[i];
      csOld[i] <= cfgCsN[i];
      if (resetPin[i] === 1'b1) begin
        rstCnt[i] <= rstCnt[i] + 8'h01;
      end
      if (convStartPin[i]) begin
        busyLeft[i] <= busyLen;
      end else if (busyLeft[i] != 8'h00) begin
        busyLeft[i] <= busyLeft[i] - 8'h01;
      end
      adcBusyPin[i] <= convStartPin[i] || busyLeft[i] > 8'h01;
      if (!cfgCsN[i] && cfgSclk[i] && !sclkOld[i]) begin
        shiftReg[i] <= {shiftReg[i][30:0], cfgSdo[i]};
        bitCnt[i] <= bitCnt[i] + 8'h01;
      end
      if (cfgCsN[i] && !csOld[i]) begin
        cfgWord[i] <= (bitCnt[i] == 8'h20) ? shiftReg[i] : ~shiftReg[i];
        frameCnt[i] <= frameCnt[i] + 8'h01;
        bitCnt[i] <= 8'h00;
      end
    end
  end
endmodule

// [dv/tb.sv]
// Self-checking bench: APB register access, setup sends, conversions and converter resets.
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] adcBusyPin, convStartPin, resetPin, cfgSclk, cfgSdo, cfgCsN;
  logic [3:0][2:0] chanSel;
  logic [7:0] busyLen = 8'h01;
  logic [3:0][31:0] cfgWord;
  logic [3:0][7:0] frameCnt, rstCnt, base, rbase;
  logic [3:0][7:0] chanCnt = '0;
  logic [31:0] rd, cfg;
  logic err;
  int failCount = 0;
  int checks = 0;

  always #50 core_clk = ~core_clk;

  acb_top dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcBusyPin(adcBusyPin), .convStartPin(convStartPin), .resetPin(resetPin), .cfgSclk(cfgSclk),
    .cfgSdo(cfgSdo), .cfgCsN(cfgCsN), .chanSel(chanSel));

  acb_adc_model adc_u (.core_clk(core_clk), .convStartPin(convStartPin), .resetPin(resetPin),
    .cfgSclk(cfgSclk), .cfgSdo(cfgSdo), .cfgCsN(cfgCsN), .busyLen(busyLen), .adcBusyPin(adcBusyPin),
    .cfgWord(cfgWord), .frameCnt(frameCnt), .rstCnt(rstCnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitIdle(input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
      n++;
    end while ((rd & mask) !== 32'h0000_0000 && n < 1000);
    check(rd & mask, 32'h0000_0000);
  endtask

  function automatic logic [31:0] expCount(input logic [31:0] c);
    return c[27] ? 32'(c[26:24]) + 32'h0000_0001 : 32'(c[25:24]) + 32'h0000_0001;
  endfunction

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (convStartPin[i] === 1'b1) begin
        check({29'h0000_0000, chanSel[i]}, {29'h0000_0000, chanCnt[i][2:0]});
        chanCnt[i] <= chanCnt[i] + 8'h01;
      end
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    failCount++;
    printVerdict();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, acb_pkg::OFS_SETUP[i], 32'h0000_0000);
      check(rd, 32'h0FFF_FFFF);
    end
    apb(1'b1, acb_pkg::OFS_STAT, 32'h0000_000F);
    apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    $display("test reset values done");
    base = frameCnt;
    for (int i = 0; i < 4; i++) apb(1'b1, acb_pkg::OFS_SETUP[i], 32'hF2C3_5A00 + i);
    apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
    check(rd, 32'h0000_000F);
    waitIdle(32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      cfg = (32'hF2C3_5A00 + i) & acb_pkg::SETUP_MASK;
      check(cfgWord[i], cfg);
      check(32'(frameCnt[i] - base[i]), 32'h0000_0001);
      apb(1'b0, acb_pkg::OFS_SETUP[i], 32'h0000_0000);
      check(rd, cfg);
    end
    $display("test setup sends done");
    for (int i = 0; i < 4; i++) begin
      cfg = (i == 0) ? 32'h0F00_0000 : (i == 1) ? 32'h0800_0000 : (i == 2) ? 32'h0700_0000 : 32'h0200_0000;
      busyLen <= i[0] ? 8'h14 : 8'h01;
      apb(1'b1, acb_pkg::OFS_SETUP[i], cfg);
      waitIdle(32'h0000_0001 << i);
      chanCnt[i] <= 8'h00;
      apb(1'b1, acb_pkg::OFS_CTRL, 32'h0000_0001 << i);
      apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
      check(rd & (32'h0000_0001 << i), 32'h0000_0001 << i);
      waitIdle(32'h0000_0001 << i);
      check(32'(chanCnt[i]), expCount(cfg));
    end
    $display("test conversions done");
    apb(1'b1, acb_pkg::OFS_SETUP[2], 32'h0B00_0000);
    waitIdle(32'h0000_0004);
    base = frameCnt;
    rbase = rstCnt;
    apb(1'b1, acb_pkg::OFS_CTRL, 32'h0004_0000);
    apb(1'b0, acb_pkg::OFS_STAT, 32'h0000_0000);
    check(rd & 32'h0000_0004, 32'h0000_0004);
    waitIdle(32'h0000_0004);
    check(32'(rstCnt[2] - rbase[2]), 32'(acb_pkg::RST_CYC));
    check(32'(frameCnt[2] - base[2]), 32'h0000_0001);
    check(cfgWord[2], 32'h0B00_0000);
    apb(1'b0, acb_pkg::OFS_CTRL, 32'h0000_0000);
    check(rd & 32'h0004_0000, 32'h0000_0000);
    $display("test converter reset done");
    busyLen <= 8'h14;
    base = frameCnt;
    apb(1'b1, acb_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b1, acb_pkg::OFS_SETUP[0], 32'h0500_0000);
    apb(1'b1, acb_pkg::OFS_SETUP[0], 32'h0900_0000);
    check({31'h0000_0000, cfgCsN[0]}, 32'h0000_0001);
    waitIdle(32'h0000_0001);
    check(32'(frameCnt[0] - base[0]), 32'h0000_0001);
    check(cfgWord[0], 32'h0900_0000);
    $display("test pending setup done");
    printVerdict();
  end
endmodule
